// *** core/mcc_top.v ***
// main clock unit: cpu prescaler, clock out, time base, tone, axi-lite regs
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "mcc_map.vh"

module mcc_top #(
   parameter [17:0] TB0_CYC    = `MCC_TB0_CYC,
   parameter [17:0] TB1_CYC    = `MCC_TB1_CYC,
   parameter [17:0] TB2_CYC    = `MCC_TB2_CYC,
   parameter [17:0] TB3_CYC    = `MCC_TB3_CYC,
   parameter [13:0] TONE1_HALF = `MCC_TONE1_HALF,
   parameter [13:0] TONE2_HALF = `MCC_TONE2_HALF,
   parameter [13:0] TONE3_HALF = `MCC_TONE3_HALF
) (
   // clock, reset, enable
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        clk_en,
   // axi4-lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // power mode control from the cpu
   input  wire        halt_req,
   input  wire        wake_irq,
   output wire        active_halt,
   output wire        full_halt,
   output wire        wake_req,
   // cpu clock enable
   output wire        cpu_clk_en,
   // clock out pin
   output reg         clock_out_pin_o,
   output wire        clock_out_pin_oe,
   // tone pin
   output reg         tone_pin_o,
   output wire        tone_pin_oe,
   // interrupt
   output wire        irq
);

   // power states
   localparam [1:0] ST_RUN   = 2'h0;
   localparam [1:0] ST_AHALT = 2'h1;
   localparam [1:0] ST_HALT  = 2'h2;

   // register state
   reg        clock_out_select_reg;
   reg [1:0]  slow_clock_divider_reg;
   reg        slow_select_reg;
   reg [1:0]  time_base_select_reg;
   reg        osc_irq_enable_reg;
   reg        time_base_flag_reg;
   reg [1:0]  tone_select_reg;
   reg        irq_mask_reg;
   reg [1:0]  state_reg;
   reg [1:0]  state_next;

   // time base and divider state
   reg [17:0] tb_cnt_reg;
   reg [1:0]  tb_cur_sel_reg;
   reg [17:0] tb_limit;
   reg [3:0]  pre_cnt_reg;
   reg [3:0]  pre_limit;
   reg [13:0] tone_cnt_reg;
   reg [13:0] tone_limit;

   // bus state
   reg        aw_full_reg;
   reg        w_full_reg;
   reg [9:0]  aw_idx_reg;
   reg [7:0]  w_data_reg;
   reg        w_lane0_reg;
   reg [7:0]  rd_mux;
   reg        rd_hit;

   wire       running;
   wire       tb_tick;
   wire       wr_go;
   wire       wr_hit;
   wire       rd_go;
   wire [9:0] ar_idx;
   wire [7:0] csr_value;

   assign running = (state_reg == ST_RUN);
   assign active_halt = (state_reg == ST_AHALT);
   assign full_halt = (state_reg == ST_HALT);

   // bus channel readiness; one write and one read at a time
   assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign rd_go  = s_axi_arvalid & s_axi_arready;
   assign ar_idx = s_axi_araddr[11:2];
   assign wr_hit = (aw_idx_reg == `MCC_CSR_IDX) |
                   (aw_idx_reg == `MCC_BEEP_IDX) |
                   (aw_idx_reg == `MCC_MASK_IDX);

   assign csr_value = {clock_out_select_reg, slow_clock_divider_reg,
                       slow_select_reg, time_base_select_reg,
                       osc_irq_enable_reg, time_base_flag_reg};

   // read data select; reserved bits read as zero
   always @* begin
      rd_mux = 8'h00;
      rd_hit = 1'b1;
      case (ar_idx)
         `MCC_CSR_IDX: begin
            rd_mux = csr_value;
         end
         `MCC_BEEP_IDX: begin
            rd_mux = {6'h00, tone_select_reg};
         end
         `MCC_MASK_IDX: begin
            rd_mux = {7'h00, irq_mask_reg};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // write address and data latches, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_idx_reg   <= 10'h000;
         w_data_reg   <= 8'h00;
         w_lane0_reg  <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MCC_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `MCC_RESP_OKAY : `MCC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `MCC_RESP_OKAY;
      end else if (clk_en) begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_mux};
            s_axi_rresp  <= rd_hit ? `MCC_RESP_OKAY : `MCC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // software registers; writes only land while running
   always @(posedge aclk) begin
      if (!aresetn) begin
         clock_out_select_reg   <= 1'b0;
         slow_clock_divider_reg <= 2'h0;
         slow_select_reg        <= 1'b0;
         time_base_select_reg   <= 2'h0;
         osc_irq_enable_reg     <= 1'b0;
         tone_select_reg        <= 2'h0;
         irq_mask_reg           <= 1'b1;
      end else if (clk_en && wr_go && w_lane0_reg && running) begin
         if (aw_idx_reg == `MCC_CSR_IDX) begin
            clock_out_select_reg   <= w_data_reg[`MCC_CSR_CLKOUT];
            slow_clock_divider_reg <=
               w_data_reg[`MCC_CSR_DIV_HI:`MCC_CSR_DIV_LO];
            slow_select_reg        <= w_data_reg[`MCC_CSR_SLOW];
            time_base_select_reg   <=
               w_data_reg[`MCC_CSR_TB_HI:`MCC_CSR_TB_LO];
            osc_irq_enable_reg     <= w_data_reg[`MCC_CSR_OIE];
         end
         if (aw_idx_reg == `MCC_BEEP_IDX) begin
            tone_select_reg <= w_data_reg[`MCC_BEEP_HI:`MCC_BEEP_LO];
         end
         if (aw_idx_reg == `MCC_MASK_IDX) begin
            irq_mask_reg <= w_data_reg[`MCC_MASK_TB];
         end
      end
   end

   // period length of the selection in force
   always @* begin
      case (tb_cur_sel_reg)
         2'h0: tb_limit = TB0_CYC - 18'h00001;
         2'h1: tb_limit = TB1_CYC - 18'h00001;
         2'h2: tb_limit = TB2_CYC - 18'h00001;
         default: tb_limit = TB3_CYC - 18'h00001;
      endcase
   end

   assign tb_tick = (tb_cnt_reg == tb_limit) & ~full_halt;

   // time-base divider, runs in run and active halt
   always @(posedge aclk) begin
      if (!aresetn) begin
         tb_cnt_reg     <= 18'h00000;
         tb_cur_sel_reg <= 2'h0;
      end else if (clk_en && !full_halt) begin
         if (tb_tick) begin
            tb_cnt_reg     <= 18'h00000;
            tb_cur_sel_reg <= time_base_select_reg;
         end else begin
            tb_cnt_reg <= tb_cnt_reg + 18'h00001;
         end
      end
   end

   // sticky flag; a new period beats a clearing read
   always @(posedge aclk) begin
      if (!aresetn) begin
         time_base_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (tb_tick) begin
            time_base_flag_reg <= 1'b1;
         end else if (rd_go && running && ar_idx == `MCC_CSR_IDX) begin
            time_base_flag_reg <= 1'b0;
         end
      end
   end

   assign irq = time_base_flag_reg & osc_irq_enable_reg & irq_mask_reg;
   assign wake_req = irq & ~full_halt;

   // power state transitions
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (halt_req) begin
               state_next = osc_irq_enable_reg ? ST_AHALT : ST_HALT;
            end
         end
         ST_AHALT: begin
            if (irq || wake_irq) begin
               state_next = ST_RUN;
            end
         end
         ST_HALT: begin
            if (wake_irq) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_RUN;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // slow-mode prescaler terminal count
   always @* begin
      case (slow_clock_divider_reg)
         2'h0: pre_limit = 4'h1;
         2'h1: pre_limit = 4'h3;
         2'h2: pre_limit = 4'h7;
         default: pre_limit = 4'hF;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_reg <= 4'h0;
      end else if (clk_en) begin
         if (!slow_select_reg || pre_cnt_reg >= pre_limit) begin
            pre_cnt_reg <= 4'h0;
         end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
         end
      end
   end

   // cpu clock enable, stopped in either halt
   assign cpu_clk_en = running &
                       (~slow_select_reg | (pre_cnt_reg == pre_limit));

   // clock out toggles once per cpu clock
   always @(posedge aclk) begin
      if (!aresetn) begin
         clock_out_pin_o <= 1'b0;
      end else if (clk_en) begin
         if (cpu_clk_en && clock_out_select_reg) begin
            clock_out_pin_o <= ~clock_out_pin_o;
         end else if (!clock_out_select_reg) begin
            clock_out_pin_o <= 1'b0;
         end
      end
   end

   assign clock_out_pin_oe = clock_out_select_reg & ~active_halt &
                             ~full_halt;

   // tone half-period select
   always @* begin
      case (tone_select_reg)
         2'h1: tone_limit = TONE1_HALF - 14'h0001;
         2'h2: tone_limit = TONE2_HALF - 14'h0001;
         default: tone_limit = TONE3_HALF - 14'h0001;
      endcase
   end

   // tone square wave, runs in active halt, frozen in full halt
   always @(posedge aclk) begin
      if (!aresetn) begin
         tone_cnt_reg <= 14'h0000;
         tone_pin_o   <= 1'b0;
      end else if (clk_en && !full_halt) begin
         if (tone_select_reg == 2'h0) begin
            tone_cnt_reg <= 14'h0000;
            tone_pin_o   <= 1'b0;
         end else if (tone_cnt_reg >= tone_limit) begin
            tone_cnt_reg <= 14'h0000;
            tone_pin_o   <= ~tone_pin_o;
         end else begin
            tone_cnt_reg <= tone_cnt_reg + 14'h0001;
         end
      end
   end

   assign tone_pin_oe = (tone_select_reg != 2'h0);

endmodule

// *** core/mcc_map.vh ***
// register map, field positions, reset values and timing counts
`ifndef MCC_MAP_VH
`define MCC_MAP_VH

// register indices; byte address is four times the index
`define MCC_CSR_IDX        10'h02C
`define MCC_BEEP_IDX       10'h02D
`define MCC_MASK_IDX       10'h02E

// control/status field positions
`define MCC_CSR_CLKOUT     7
`define MCC_CSR_DIV_HI     6
`define MCC_CSR_DIV_LO     5
`define MCC_CSR_SLOW       4
`define MCC_CSR_TB_HI      3
`define MCC_CSR_TB_LO      2
`define MCC_CSR_OIE        1
`define MCC_CSR_FLAG       0

// tone control and interrupt mask field positions
`define MCC_BEEP_HI        1
`define MCC_BEEP_LO        0
`define MCC_MASK_TB        0

// reset values
`define MCC_CSR_RST        8'h00
`define MCC_BEEP_RST       8'h00
`define MCC_MASK_RST       8'h01

// time-base periods in oscillator cycles
`define MCC_TB0_CYC        18'h03E80
`define MCC_TB1_CYC        18'h07D00
`define MCC_TB2_CYC        18'h13880
`define MCC_TB3_CYC        18'h30D40

// tone frequencies at the reference oscillator rate
`define MCC_TONE_REF_HZ    8000000
`define MCC_TONE1_HZ       2000
`define MCC_TONE2_HZ       1000
`define MCC_TONE3_HZ       500
// tone half periods in oscillator cycles at the reference rate
`define MCC_TONE1_HALF     14'h07D0
`define MCC_TONE2_HALF     14'h0FA0
`define MCC_TONE3_HALF     14'h1F40

// bus responses
`define MCC_RESP_OKAY      2'h0
`define MCC_RESP_SLVERR    2'h2

`endif

// *** core/mcc_unused.v ***
// empty: no further logic
`timescale 1ns/1ns

// *** verif/mcc_assertions.sv ***
// port assertions for the main clock unit
`timescale 1ns/1ns
module mcc_assertions (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   input logic clk_en,
   // power mode and pins
   input logic halt_req,
   input logic wake_irq,
   input logic active_halt,
   input logic full_halt,
   input logic wake_req,
   input logic cpu_clk_en,
   input logic clock_out_pin_oe,
   input logic tone_pin_o,
   input logic tone_pin_oe,
   input logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // power mode entry and exit
   property p_enter;
      halt_req && clk_en && !active_halt && !full_halt
         |=> active_halt || full_halt;
   endproperty
   a_enter: assert property (p_enter) else $error("no halt entry");
   property p_ah_exit;
      active_halt && irq && clk_en |=> !active_halt;
   endproperty
   a_ah_exit: assert property (p_ah_exit) else $error("no wake");
   property p_fh_hold;
      full_halt && !wake_irq |=> full_halt;
   endproperty
   a_fh_hold: assert property (p_fh_hold) else $error("left halt");
   property p_wake;
      wake_req |-> irq && !full_halt;
   endproperty
   a_wake: assert property (p_wake) else $error("bad wake");
   // clocks and pins while halted
   property p_cpu_stop;
      active_halt || full_halt |-> !cpu_clk_en;
   endproperty
   a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clk");
   property p_co_off;
      active_halt |-> !clock_out_pin_oe;
   endproperty
   a_co_off: assert property (p_co_off) else $error("clock out");
   property p_tone_frz;
      full_halt && $past(full_halt) |-> $stable(tone_pin_o);
   endproperty
   a_tone_frz: assert property (p_tone_frz) else $error("tone ran");
   property p_tone_run;
      active_halt && tone_pin_oe |->
         ##[1:40] ($changed(tone_pin_o) || full_halt);
   endproperty
   a_tone_run: assert property (p_tone_run) else $error("tone hung");
   // main scenarios reached
   c_ah: cover property ($rose(active_halt));
   c_fh: cover property ($rose(full_halt));
   c_irq: cover property ($rose(irq));
endmodule

bind mcc_top mcc_assertions chk_u (.aclk(aclk), .aresetn(aresetn),
   .clk_en(clk_en), .halt_req(halt_req), .wake_irq(wake_irq),
   .active_halt(active_halt), .full_halt(full_halt), .wake_req(wake_req),
   .cpu_clk_en(cpu_clk_en), .clock_out_pin_oe(clock_out_pin_oe),
   .tone_pin_o(tone_pin_o), .tone_pin_oe(tone_pin_oe), .irq(irq));

// *** verif/mcc_top_tb.sv ***
// self-checking bench for the main clock unit
`timescale 1ns/1ns
`include "mcc_map.vh"
module mcc_top_tb;
   localparam int CS = `MCC_CSR_IDX * 4;
   localparam int BP = `MCC_BEEP_IDX * 4;
   localparam int MK = `MCC_MASK_IDX * 4;
   localparam logic [33:0] ALL = 34'h3FFFFFFFF;
   localparam logic [33:0] NOF = 34'h3FFFFFFFE;
   logic        aclk = 0, aresetn = 0, clk_en = 1;
   logic        halt_req = 0, wake_irq = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, active_halt, full_halt, wake_req, cpu_clk_en;
   wire         clock_out_pin_o, clock_out_pin_oe, tone_pin_o, tone_pin_oe;
   wire         irq;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [33:0]  rg = {s_axi_rresp, s_axi_rdata};
   int          error_cnt = 0, tests_run = 0, cyc = 0;
   int          per[4] = '{16, 32, 80, 200};
   int          hf[4] = '{0, `MCC_TONE_REF_HZ / (2 * `MCC_TONE1_HZ),
                          `MCC_TONE_REF_HZ / (2 * `MCC_TONE2_HZ), 32};
   logic [33:0] eq[$], mq[$];
   logic [1:0]  bq[$];

   mcc_top #(.TB0_CYC(16), .TB1_CYC(32), .TB2_CYC(80), .TB3_CYC(200),
      .TONE3_HALF(32)) dut_u (.*);

   // clock and cycle count
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic tmo(int n);
      if (n >= 200) begin
         error_cnt++;
         $display("[FAIL] wait exp done got timeout");
         wrap_up;
      end
   endtask

   // bus write: both channels offered, released as taken
   task automatic wr(int a, logic [7:0] d, logic [3:0] s, logic [1:0] r);
      int n;
      @(posedge aclk);
      bq.push_back(r);
      s_axi_awaddr <= a[11:0];
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 0;
      tmo(n);
   endtask

   // bus read with expected value and care mask
   task automatic rd(int a, logic [33:0] e, logic [33:0] m);
      int n;
      @(posedge aclk);
      eq.push_back(e);
      mq.push_back(m);
      s_axi_araddr <= a[11:0];
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 0;
      tmo(n);
   endtask

   // wait for a tone edge or a raised interrupt
   task automatic wt(input bit tn, output int t);
      logic p;
      int n;
      p = tone_pin_o;
      for (n = 0; n < 5000; n++) begin
         @(posedge aclk);
         if (tn ? tone_pin_o !== p : irq === 1'b1) break;
      end
      t = cyc;
      tmo(n / 25);
   endtask

   // count cpu enables and clock-out toggles over 64 cycles
   task automatic cnt(output int ce, output int tg);
      logic p;
      ce = 0;
      tg = 0;
      p = clock_out_pin_o;
      repeat (64) begin
         @(posedge aclk);
         ce += cpu_clk_en;
         tg += (clock_out_pin_o !== p);
         p = clock_out_pin_o;
      end
   endtask

   task automatic hlt;
      halt_req <= 1;
      @(posedge aclk);
      halt_req <= 0;
      repeat (2) @(posedge aclk);
   endtask

   // scoreboard: oldest note against each response
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk("rdata", eq[0] & mq[0], rg & mq[0]);
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk("bresp", {32'h0, bq[0]}, {32'h0, s_axi_bresp});
         void'(bq.pop_front());
      end
   end

   initial begin
      int a, b, bp, ce, tg, k;
      logic tp;
      void'($urandom(32'h305C));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      // reset values and an unmapped slot
      rd(CS, 0, ALL);
      rd(BP, 0, ALL);
      rd(MK, 1, ALL);
      rd(12'hC0, {2'h2, 32'h0}, ALL);
      wr(12'hC0, 8'h00, 4'h1, 2'h2);
      // tone rates; a write without strobe is dropped
      for (k = 1; k < 4; k++) begin
         wr(BP, k[7:0], 4'h1, 0);
         wr(BP, 8'($urandom) & 8'h03, 4'h0, 0);
         rd(BP, k, ALL);
         chk("tone oe", 1, tone_pin_oe);
         repeat (2) wt(1, a);
         wt(1, b);
         chk("tone half", hf[k], b - a);
      end
      // a low clock enable freezes the tone divider
      clk_en <= 0;
      @(posedge aclk);
      tp = tone_pin_o;
      tg = 0;
      repeat (64) begin
         @(posedge aclk);
         tg += (tone_pin_o !== tp);
      end
      clk_en <= 1;
      chk("frozen tone", 0, tg);
      // periods; a stale flag may be pending, the third wait is aligned
      wr(CS, 8'h02, 4'h1, 0);
      repeat (3) begin
         wt(0, bp);
         rd(CS, 8'h02, NOF);
      end
      for (k = 0; k < 4; k++) begin
         wr(CS, 8'(2 + 4 * k), 4'h1, 0);
         wt(0, a);
         rd(CS, 2 + 4 * k, NOF);
         wt(0, b);
         rd(CS, 2 + 4 * k, NOF);
         chk("old period", per[k > 0 ? k - 1 : 0], a - bp);
         chk("period", per[k], b - a);
         bp = b;
      end
      // mask and enable gate the request, the flag stays pending
      wr(MK, 8'h00, 4'h1, 0);
      repeat (220) @(posedge aclk);
      chk("masked irq", 0, irq);
      wr(MK, 8'h01, 4'h1, 0);
      chk("irq", 1, irq);
      wr(CS, 8'h00, 4'h1, 0);
      chk("no enable irq", 0, irq);
      rd(CS, 1, ALL);
      // cpu clock and clock-out pin for every divider and normal mode
      for (k = 0; k < 5; k++) begin
         wr(CS, k < 4 ? 8'(8'h90 + 32 * k) : 8'h80, 4'h1, 0);
         cnt(ce, tg);
         chk("cpu rate", k < 4 ? 64 >> (k + 1) : 64, ce);
         chk("clock out", k < 4 ? 64 >> (k + 1) : 64, tg);
         chk("clock out oe", 1, clock_out_pin_oe);
      end
      // active halt: pin released, counter runs, writes dropped
      wr(CS, 8'h8E, 4'h1, 0);
      repeat (3) begin
         wt(0, a);
         rd(CS, 8'h8E, NOF);
      end
      hlt;
      chk("active halt", 1, active_halt);
      chk("halt oe", 0, clock_out_pin_oe);
      wr(CS, 8'h00, 4'h1, 0);
      wt(0, b);
      chk("halt period", per[3], b - a);
      @(posedge aclk);
      chk("woken", 0, active_halt);
      rd(CS, 8'h8F, ALL);
      // full halt: only the wake line ends it
      wr(CS, 8'h0C, 4'h1, 0);
      hlt;
      chk("full halt", 1, full_halt);
      repeat (300) @(posedge aclk);
      chk("still halted", 1, full_halt);
      wake_irq <= 1;
      @(posedge aclk);
      wake_irq <= 0;
      repeat (2) @(posedge aclk);
      chk("resumed", 0, full_halt);
      wrap_up;
   end
endmodule
